// File: logic/slcr_pkg.sv
// Constants, types and register map of the serial lane configuration group.
// Assumes a byte-wide register port driven by the serial port decoder.
//
// How it works
// - Read-only high density flag at bit 7
// - Read-only control words per frame in [4:0]
// - Lane 0 checksum is parameter sum mod 256
// - Lane 1 checksum from its own parameters
// - Power-down bit 0 forces lane 0 off
// - Power-down bit 2 forces lane 1 off
// - Lane 0 source field, logical lanes 0-7
// - Lane 1 source field, resets to lane 1
// - Per-lane 3-bit swing code, resets 0x1
package slcr_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [12:0] SLCR_OFS_DENSITY = 13'h0592;
    localparam logic [12:0] SLCR_OFS_CSUM0 = 13'h05a0;
    localparam logic [12:0] SLCR_OFS_CSUM1 = 13'h05a1;
    localparam logic [12:0] SLCR_OFS_PWRDN = 13'h05b0;
    localparam logic [12:0] SLCR_OFS_MAP0 = 13'h05b2;
    localparam logic [12:0] SLCR_OFS_MAP1 = 13'h05b3;
    localparam logic [12:0] SLCR_OFS_SWING0 = 13'h05c0;
    localparam logic [12:0] SLCR_OFS_SWING1 = 13'h05c1;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int SLCR_HD_BIT = 7;
    localparam int SLCR_PD0_BIT = 0;
    localparam int SLCR_PD1_BIT = 2;
    localparam logic [7:0] SLCR_CSUM0_RST = 8'hc3;
    localparam logic [7:0] SLCR_CSUM1_RST = 8'hc4;
    localparam logic [7:0] SLCR_PWRDN_RST = 8'hfa;
    localparam logic [2:0] SLCR_MAP0_RST = 3'h0;
    localparam logic [2:0] SLCR_MAP1_RST = 3'h1;
    localparam logic [2:0] SLCR_MAP_RSV_RST0 = 3'h0;
    localparam logic [2:0] SLCR_MAP_RSV_RST1 = 3'h1;
    localparam logic [2:0] SLCR_SWING_RST = 3'h1;
    localparam logic [2:0] SLCR_SWING_FULL = 3'h0;
    // ----------------------------------------
    // Register port carrier
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [12:0] addr;
        logic [7:0] wdata;
    } slcr_req_t;
    // Per-lane controls leaving the block
    typedef struct packed {
        logic power_down;
        logic [2:0] logical_lane;
        logic [2:0] swing;
    } slcr_lane_t;
endpackage

// File: logic/slcr_regs.sv
// Register group for the serial transmit lanes: link parameters, checksums,
// lane power-down, physical-to-logical lane mapping and output swing.
// Assumes a same-clock serial port decoder issuing one-cycle read/write strobes.
// Assumes the link transmitter supplies its status and parameter sums on this
// clock, so they are registered once here and need no synchroniser.
`timescale 1ns/1ps
`default_nettype none
module slcr_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire slcr_pkg::slcr_req_t req_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // Link parameters from the link transmitter
    input wire logic high_density_flag_in,
    input wire logic [4:0] control_words_per_frame_in,
    input wire logic [7:0] lane0_param_sum_in,
    input wire logic [7:0] lane1_param_sum_in,
    // Lane controls
    output slcr_pkg::slcr_lane_t lane0_out,
    output slcr_pkg::slcr_lane_t lane1_out
);
    import slcr_pkg::*;

    logic [7:0] pwrdn_r;
    logic [2:0] map0_r, map1_r, map0_rsv_r, map1_rsv_r;
    logic [2:0] swing0_r, swing1_r;
    logic hd_r;
    logic [4:0] cf_r;
    logic [7:0] csum0_r, csum1_r;
    logic [7:0] rdata_nxt;
    logic wr_pwrdn, wr_map0, wr_map1, wr_swing0, wr_swing1;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Write hit on one offset, shared by every writable register
    function automatic logic wr_hit(input slcr_req_t req, input logic [12:0] ofs);
        return req.wr && (req.addr == ofs);
    endfunction

    // Decoded write strobes, one per writable offset.
    // Writes to read-only or unmapped offsets match none and are dropped,
    // so software cannot disturb the status bytes by a stray write.
    // The full 13-bit offset is compared: no aliasing into other pages.
    always_comb begin
        wr_pwrdn = wr_hit(req_in, SLCR_OFS_PWRDN);
        wr_map0 = wr_hit(req_in, SLCR_OFS_MAP0);
        wr_map1 = wr_hit(req_in, SLCR_OFS_MAP1);
        wr_swing0 = wr_hit(req_in, SLCR_OFS_SWING0);
        wr_swing1 = wr_hit(req_in, SLCR_OFS_SWING1);
    end

    // ----------------------------------------
    // Link status capture
    // ----------------------------------------
    // high density flag
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hd_r <= 1'b0;
        end else begin
            hd_r <= high_density_flag_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cf_r <= 5'h00;
        end else begin
            cf_r <= control_words_per_frame_in;
        end
    end
    // lane 0 and lane 1 checksums, sums already wrap at 8 bits
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            csum0_r <= SLCR_CSUM0_RST;
            csum1_r <= SLCR_CSUM1_RST;
        end else begin
            csum0_r <= lane0_param_sum_in;
            csum1_r <= lane1_param_sum_in;
        end
    end

    // ----------------------------------------
    // Writable controls
    // ----------------------------------------
    // lane power-down register, reserved bits kept writable
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwrdn_r <= SLCR_PWRDN_RST;
        end else if (wr_pwrdn) begin
            pwrdn_r <= req_in.wdata;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            map0_r <= SLCR_MAP0_RST;
            map0_rsv_r <= SLCR_MAP_RSV_RST0;
        end else if (wr_map0) begin
            map0_r <= req_in.wdata[2:0];
            map0_rsv_r <= req_in.wdata[6:4];
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            map1_r <= SLCR_MAP1_RST;
            map1_rsv_r <= SLCR_MAP_RSV_RST1;
        end else if (wr_map1) begin
            map1_r <= req_in.wdata[2:0];
            map1_rsv_r <= req_in.wdata[6:4];
        end
    end

    // Swing codes: code 0 is full driver supply swing, reset is the
    // reduced swing. Codes are passed on unchecked; the driver decodes them.
    // lane 0 swing code
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            swing0_r <= SLCR_SWING_RST;
        end else if (wr_swing0) begin
            swing0_r <= req_in.wdata[2:0];
        end
    end

    // lane 1 swing code, independent of lane 0
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            swing1_r <= SLCR_SWING_RST;
        end else if (wr_swing1) begin
            swing1_r <= req_in.wdata[2:0];
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Read-only fixed bits return zero; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (req_in.addr)
            SLCR_OFS_DENSITY: rdata_nxt = {hd_r, 2'b00, cf_r};
            SLCR_OFS_CSUM0: rdata_nxt = csum0_r;
            SLCR_OFS_CSUM1: rdata_nxt = csum1_r;
            SLCR_OFS_PWRDN: rdata_nxt = pwrdn_r;
            SLCR_OFS_MAP0: rdata_nxt = {1'b0, map0_rsv_r, 1'b0, map0_r};
            SLCR_OFS_MAP1: rdata_nxt = {1'b0, map1_rsv_r, 1'b0, map1_r};
            SLCR_OFS_SWING0: rdata_nxt = {5'h00, swing0_r};
            SLCR_OFS_SWING1: rdata_nxt = {5'h00, swing1_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read valid pulse, one cycle after the strobe.
    // Back-to-back reads give back-to-back pulses; no wait state exists.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= req_in.rd;
        end
    end

    // Registered read data, held until the next read.
    // Holding it lets a slow decoder pick the byte up late.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (req_in.rd) begin
            rdata_out <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Lane control outputs
    // ----------------------------------------
    // Controls are registered once more so the lane logic sees clean,
    // glitch-free levels; the cost is one cycle of extra latency.
    // Duplicate logical lanes are not caught here; software must avoid them.
    // lane 0 power-down, mapping and swing outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lane0_out <= '{1'b0, SLCR_MAP0_RST, SLCR_SWING_RST};
        end else begin
            lane0_out <= '{pwrdn_r[SLCR_PD0_BIT], map0_r, swing0_r};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lane1_out <= '{1'b0, SLCR_MAP1_RST, SLCR_SWING_RST};
        end else begin
            lane1_out <= '{pwrdn_r[SLCR_PD1_BIT], map1_r, swing1_r};
        end
    end
endmodule
`default_nettype wire

// File: tb/slcr_chk.sv
// Port checker for slcr_regs.
// Assumes link inputs hold steady around status reads.
`timescale 1ns/1ps
`default_nettype none
module slcr_chk (
    // Watched ports
    input wire logic clk_in,
    input wire logic rst_in,
    input wire slcr_pkg::slcr_req_t req_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic high_density_flag_in,
    input wire logic [4:0] control_words_per_frame_in,
    input wire logic [7:0] lane0_param_sum_in,
    input wire logic [7:0] lane1_param_sum_in,
    input wire slcr_pkg::slcr_lane_t lane0_out,
    input wire slcr_pkg::slcr_lane_t lane1_out
);
    import slcr_pkg::*;
    // Status reads see inputs two edges back, lanes lag writes by two
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire [12:0] a = req_in.addr;
    wire r = req_in.rd;
    wire w = req_in.wr;
    a_rd_valid: assert property (rvalid_out == $past(r)) else $error("rvalid");
    a_hd_cf: assert property (r && a == SLCR_OFS_DENSITY |=> rdata_out ==
        {$past(high_density_flag_in, 2), 2'h0, $past(control_words_per_frame_in, 2)}) else $error("hd cf");
    a_sum_lane0: assert property (r && a == SLCR_OFS_CSUM0 |=>
        rdata_out == $past(lane0_param_sum_in, 2)) else $error("csum0");
    a_sum_lane1: assert property (r && a == SLCR_OFS_CSUM1 |=>
        rdata_out == $past(lane1_param_sum_in, 2)) else $error("csum1");
    a_pd_lane0: assert property (w && a == SLCR_OFS_PWRDN |-> ##2
        lane0_out.power_down == $past(req_in.wdata[0], 2)) else $error("pd0");
    a_pd_lane1: assert property (w && a == SLCR_OFS_PWRDN |-> ##2
        lane1_out.power_down == $past(req_in.wdata[2], 2)) else $error("pd1");
    a_map_lane1: assert property (w && a == SLCR_OFS_MAP1 |-> ##2
        lane1_out.logical_lane == $past(req_in.wdata[2:0], 2)) else $error("map1");
    a_swing_lane0: assert property (w && a == SLCR_OFS_SWING0 |-> ##2
        lane0_out.swing == $past(req_in.wdata[2:0], 2)) else $error("swing0");
    a_map_lane0: assert property (w && a == SLCR_OFS_MAP0 |-> ##2
        lane0_out.logical_lane == $past(req_in.wdata[2:0], 2)) else $error("map0");
    a_swing_lane1: assert property (w && a == SLCR_OFS_SWING1 |-> ##2
        lane1_out.swing == $past(req_in.wdata[2:0], 2)) else $error("swing1");
endmodule
`default_nettype wire

// File: tb/slcr_link_model.sv
// Far-end link model: parameter sums follow lane mapping.
// Assumes a purely combinational hookup.
`timescale 1ns/1ps
`default_nettype none
module slcr_link_model (
    // Lane controls in, link parameters out
    input wire slcr_pkg::slcr_lane_t l0_in,
    input wire slcr_pkg::slcr_lane_t l1_in,
    output logic hd_out,
    output logic [4:0] cf_out,
    output logic [7:0] s0_out,
    output logic [7:0] s1_out
);
    assign {hd_out, cf_out} = 6'h2b;
    assign s0_out = 8'hfe + 8'(l0_in.logical_lane);
    assign s1_out = 8'hfe + 8'(l1_in.logical_lane);
endmodule
`default_nettype wire

// File: tb/serial_lane_config_regs_tb_top.sv
// Bench: strobe-port accesses against expected values.
// Assumes slcr_regs, the link model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module serial_lane_config_regs_tb_top;
    import slcr_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, rvalid_out, high_density_flag_in;
    logic [4:0] control_words_per_frame_in;
    logic [7:0] rdata_out, lane0_param_sum_in, lane1_param_sum_in;
    slcr_req_t req_in = '0;
    slcr_lane_t lane0_out, lane1_out;
    int bad_count = 0, n_checks = 0;
    slcr_regs dut (.clk_in, .rst_in, .req_in, .rdata_out, .rvalid_out, .high_density_flag_in,
        .control_words_per_frame_in, .lane0_param_sum_in, .lane1_param_sum_in, .lane0_out, .lane1_out);
    slcr_link_model far_end (.l0_in(lane0_out), .l1_in(lane1_out), .hd_out(high_density_flag_in),
        .cf_out(control_words_per_frame_in), .s0_out(lane0_param_sum_in), .s1_out(lane1_param_sum_in));
    // Free-running 100 ns clock
    initial forever #50 clk_in = ~clk_in;
    // Compare, counting every check
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One strobe; a read checks valid and data at the next low phase
    task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
        req_in <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_in);
        req_in <= '0;
        @(negedge clk_in);
        if (!w) chk({rvalid_out, rdata_out}, {1'b1, d});
        @(posedge clk_in);
    endtask
    // Reset, then register traffic; reads settle lanes before lane checks
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        acc(1'b0, SLCR_OFS_PWRDN, 8'hfa);
        acc(1'b0, SLCR_OFS_MAP1, 8'h11);
        chk({2'h0, lane0_out}, 9'h001);
        chk({2'h0, lane1_out}, 9'h009);
        acc(1'b1, SLCR_OFS_DENSITY, 8'h00);
        acc(1'b0, SLCR_OFS_DENSITY, 8'h8b);
        acc(1'b0, 13'h05b1, 8'h00);
        acc(1'b1, SLCR_OFS_PWRDN, 8'hff);
        acc(1'b0, SLCR_OFS_PWRDN, 8'hff);
        chk({7'h0, lane0_out.power_down, lane1_out.power_down}, 9'h003);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, SLCR_OFS_MAP0, 8'(k));
            acc(1'b1, SLCR_OFS_MAP1, 8'(8'h13 - k));
            acc(1'b0, SLCR_OFS_MAP0, 8'(k));
            chk(9'({lane0_out.logical_lane, lane1_out.logical_lane}), 9'(k * 8 + 3 - k));
            acc(1'b0, SLCR_OFS_CSUM0, 8'(8'hfe + k));
            acc(1'b0, SLCR_OFS_CSUM1, 8'(8'h01 - k));
        end
        acc(1'b1, SLCR_OFS_SWING0, 8'h00);
        acc(1'b1, SLCR_OFS_SWING1, 8'h03);
        acc(1'b0, SLCR_OFS_SWING0, 8'h00);
        acc(1'b0, SLCR_OFS_SWING1, 8'h03);
        chk({lane0_out.swing, lane1_out.swing, 3'h0}, 9'h018);
        close_out();
    end
endmodule
bind slcr_regs slcr_chk u_chk (.clk_in, .rst_in, .req_in, .rdata_out, .rvalid_out, .high_density_flag_in,
    .control_words_per_frame_in, .lane0_param_sum_in, .lane1_param_sum_in, .lane0_out, .lane1_out);
`default_nettype wire
